// File: hdl/encoder_counter_params.svh
// Offsets, field positions, reset values and timing counts of the counter.
// Assumes a 100 MHz pclk; included by the counter channel and the bench.
`ifndef ENCODER_COUNTER_PARAMS_SVH
`define ENCODER_COUNTER_PARAMS_SVH

`define EC_ADDR_CTRL     8'h00
`define EC_ADDR_INT_EN   8'h04
`define EC_ADDR_CMP      8'h08
`define EC_ADDR_LOAD     8'h0C
`define EC_ADDR_TIMING   8'h10
`define EC_ADDR_STATUS   8'h14
`define EC_ADDR_COUNT    8'h18
`define EC_ADDR_LATCH    8'h1C

`define EC_CTRL_RUN_EN   0
`define EC_CTRL_DO_EN    1
`define EC_CTRL_SET_DO   2
`define EC_CTRL_HW_EN    3
`define EC_CTRL_DIR_INV  4
`define EC_CTRL_EVAL_LO  5
`define EC_CTRL_OMODE_LO 8
`define EC_CTRL_FCNT_LO  10
`define EC_CTRL_FLAT_LO  13
`define EC_CTRL_STOP     16
`define EC_CTRL_RESET    32'h0000_4400

`define EC_TIM_HYST_LO   0
`define EC_TIM_PULSE_LO  16

`define EC_ST_GATE       0
`define EC_ST_PIN_GATE   1
`define EC_ST_LATCH      2
`define EC_ST_DO         3
`define EC_ST_CMP        4
`define EC_ST_OFLW       5
`define EC_ST_UFLW       6

`define EC_IRQ_HW_OPEN   0
`define EC_IRQ_HW_CLOSE  1
`define EC_IRQ_CMP       2
`define EC_IRQ_OFLW      3
`define EC_IRQ_UFLW      4

`define EC_CLK_NS        10
`define EC_F0_KHZ        60
`define EC_F1_KHZ        30
`define EC_F2_KHZ        10
`define EC_F3_KHZ        5
`define EC_F4_KHZ        2
`define EC_F5_KHZ        1
// Half period in cycles, rounded up: 1e6 ns / (2 * f_khz * clk_ns)
`define EC_HALF_CYC(f) ((500000 + (f) * `EC_CLK_NS - 1) / ((f) * `EC_CLK_NS))
`define EC_PULSE_UNIT_NS 1024000
`define EC_PULSE_UNIT_CYC (`EC_PULSE_UNIT_NS / `EC_CLK_NS)

`endif

// File: hdl/encoder_counter_pkg.sv
// Types shared by the counter channel and its filter.
// Assumes encoder_counter_params.svh holds all numeric constants.
package encoder_counter_pkg;
  typedef enum logic [1:0] {
    EVAL_PULSE_DIR, EVAL_QUAD_X1, EVAL_QUAD_X2, EVAL_QUAD_X4
  } eval_mode_e;
  typedef enum logic [1:0] {
    OUT_NONE, OUT_GE, OUT_LE, OUT_PULSE
  } out_mode_e;
  typedef logic [15:0] filt_cnt_t;
endpackage

// File: hdl/input_filter.sv
// Glitch filter: the output follows the input only after it held stable.
// Assumes din is already synchronised to pclk.
`timescale 1ns/100ps
module input_filter (
  input  wire logic                           pclk,    // System clock
  input  wire logic                           presetn, // Async reset
  input  wire logic                           din,     // Synced input
  input  wire encoder_counter_pkg::filt_cnt_t limit,   // Stable cycles
  output logic                                dout     // Filtered level
);
  encoder_counter_pkg::filt_cnt_t cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 16'h0000;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt <= 16'h0000;
    end else if (cnt >= limit - 16'h0001) begin
      dout <= din;
      cnt  <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  a_filt_stable: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(dout) |-> $past(cnt) >= $past(limit) - 16'h0001)
    else $error("filter output changed before the input was stable");
endmodule

// File: hdl/encoder_counter_config.sv
// Incremental counter channel with APB registers, filters and comparator.
// Assumes asynchronous encoder, gate and latch pins; one 100 MHz clock.
//
// Behaviour
// - Comparator hysteresis 0..255 counts; 0 or 1 disables it.
// - Track A, B and hardware gate filtered at 60/30/10/5/2/1 kHz, 30 default.
// - Latch input filtered separately from the same set, 10 kHz default.
// - Evaluation: pulse/direction (default) or quadrature x1, x2, x4.
// - Hardware gating enabled ANDs hardware gate with software gate; off default.
// - Direction inversion flips the direction input; off by default.
// - Output and comparator flag follow mode: none, >=, <=, pulse; none default.
// - Pulse mode holds output for even setting 0..510 times 1.024 ms.
// - Optional interrupt when hardware gate opens while software gate open.
// - Optional interrupt when hardware gate closes while software gate open.
// - Optional interrupt on comparison match; none in no-comparison mode.
// - Optional interrupt on count overflow above upper limit; off default.
// - Optional interrupt on count underflow below lower limit; off default.
// - Software starts and stops counting and controls the digital output.
// - Count and latched value readable by software at any time.
// - Rising latch input copies current count into the latch register.
// - Hardware gate opens on rising input edge, closes on falling edge.
// - In >= and <= modes output holds while the relation is true.
// - Stop mode freezes and resumes count; cancel mode reloads on reopening.
`timescale 1ns/100ps
`include "encoder_counter_params.svh"
module encoder_counter_config #(
  parameter int filt_cyc_10k   = `EC_HALF_CYC(`EC_F2_KHZ),
  parameter int filt_cyc_5k    = `EC_HALF_CYC(`EC_F3_KHZ),
  parameter int filt_cyc_2k    = `EC_HALF_CYC(`EC_F4_KHZ),
  parameter int filt_cyc_1k    = `EC_HALF_CYC(`EC_F5_KHZ),
  parameter int pulse_unit_cyc = `EC_PULSE_UNIT_CYC
) (
  input  wire logic        pclk,         // System clock
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB write
  input  wire logic [31:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  input  wire logic        track_a,      // Track A / pulse pin
  input  wire logic        track_b,      // Track B / direction pin
  input  wire logic        hardware_gate_input, // Hardware gate pin
  input  wire logic        latch_in,     // Latch pin
  output logic             counter_do,   // Digital output
  output logic             irq_pulse,    // Hardware interrupt pulse
  output logic      [4:0]  irq_cause     // Source of irq_pulse
);
  logic [31:0] ctrl, int_en, cmp_val, load_val, timing;
  logic signed [31:0] count, latch_val;
  logic [3:0] sync1, sync2, filt, filt_q;
  logic       int_gate, int_gate_q, count_chg;
  logic       comparator_reached_flag, oflw_flag, uflw_flag;
  logic       cmp_out, cmp_out_q, armed;
  logic [8:0] pulse_left;
  logic [16:0] unit_div;
  logic       step_up, step_dn, q_up, q_dn, ovf_evt, ufl_evt, hit;
  logic       next_cmp_out;

  wire encoder_counter_pkg::eval_mode_e eval_mode =
    encoder_counter_pkg::eval_mode_e'(ctrl[`EC_CTRL_EVAL_LO +: 2]);
  wire encoder_counter_pkg::out_mode_e out_mode =
    encoder_counter_pkg::out_mode_e'(ctrl[`EC_CTRL_OMODE_LO +: 2]);
  wire        software_gate_bit = ctrl[`EC_CTRL_RUN_EN];
  wire        hw_en    = ctrl[`EC_CTRL_HW_EN];
  wire        dir_inv  = ctrl[`EC_CTRL_DIR_INV];
  wire        stop_mode = ctrl[`EC_CTRL_STOP];
  wire [7:0]  hyst     = timing[`EC_TIM_HYST_LO +: 8];
  wire [8:0]  pulse_dur = {timing[`EC_TIM_PULSE_LO + 1 +: 8], 1'b0};
  wire        wr_en = psel & penable & pready & pwrite;

  // Filter step select to stable-cycle count
  function automatic encoder_counter_pkg::filt_cnt_t lim(input logic [2:0] s);
    case (s)
      3'd0:    lim = 16'(`EC_HALF_CYC(`EC_F0_KHZ));
      3'd1:    lim = 16'(`EC_HALF_CYC(`EC_F1_KHZ));
      3'd2:    lim = 16'(filt_cyc_10k);
      3'd3:    lim = 16'(filt_cyc_5k);
      3'd4:    lim = 16'(filt_cyc_2k);
      default: lim = 16'(filt_cyc_1k);
    endcase
  endfunction

  // Pins: A, B, hardware gate, latch; two flops then filter
  wire [3:0] pins = {latch_in, hardware_gate_input, track_b, track_a};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1  <= 4'h0;
      sync2  <= 4'h0;
      filt_q <= 4'h0;
    end else begin
      sync1  <= pins;
      sync2  <= sync1;
      filt_q <= filt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      input_filter u_filt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sync2[gi]),
        .limit   (gi == 3 ? lim(ctrl[`EC_CTRL_FLAT_LO +: 3])
                          : lim(ctrl[`EC_CTRL_FCNT_LO +: 3])),
        .dout    (filt[gi])
      );
    end
  endgenerate

  wire a_f = filt[0];
  wire b_f = filt[1];
  wire a_rise = filt[0] & ~filt_q[0];
  wire a_fall = ~filt[0] & filt_q[0];
  wire b_rise = filt[1] & ~filt_q[1];
  wire b_fall = ~filt[1] & filt_q[1];
  wire hw_open  = filt[2] & ~filt_q[2];
  wire hw_close = ~filt[2] & filt_q[2];
  wire latch_rise = filt[3] & ~filt_q[3];

  // Count step decode per evaluation mode
  always_comb begin
    q_up = 1'b0;
    q_dn = 1'b0;
    case (eval_mode)
      encoder_counter_pkg::EVAL_PULSE_DIR: begin
        q_up = a_rise & ~(b_f ^ dir_inv);
        q_dn = a_rise & (b_f ^ dir_inv);
      end
      encoder_counter_pkg::EVAL_QUAD_X1: begin
        q_up = a_rise & ~b_f;
        q_dn = a_fall & ~b_f;
      end
      encoder_counter_pkg::EVAL_QUAD_X2: begin
        q_up = (a_rise & ~b_f) | (a_fall & b_f);
        q_dn = (a_rise & b_f) | (a_fall & ~b_f);
      end
      default: begin
        q_up = (a_rise & ~b_f) | (a_fall & b_f) |
               (b_rise & a_f) | (b_fall & ~a_f);
        q_dn = (a_rise & b_f) | (a_fall & ~b_f) |
               (b_rise & ~a_f) | (b_fall & a_f);
      end
    endcase
    step_up = (eval_mode == encoder_counter_pkg::EVAL_PULSE_DIR) ? q_up :
              (dir_inv ? q_dn : q_up);
    step_dn = (eval_mode == encoder_counter_pkg::EVAL_PULSE_DIR) ? q_dn :
              (dir_inv ? q_up : q_dn);
  end

  wire gate_now  = software_gate_bit & (~hw_en | filt[2]);
  wire gate_rise = int_gate & ~int_gate_q;
  assign ovf_evt = int_gate & step_up & (count == 32'sh7FFF_FFFF);
  assign ufl_evt = int_gate & step_dn & (count == 32'sh8000_0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_gate   <= 1'b0;
      int_gate_q <= 1'b0;
    end else begin
      int_gate   <= gate_now;
      int_gate_q <= int_gate;
    end
  end

  // Counter; stop mode keeps value, cancel mode reloads on reopening
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count     <= 32'sh0000_0000;
      count_chg <= 1'b0;
    end else begin
      count_chg <= 1'b0;
      if (gate_rise && !stop_mode) begin
        count     <= signed'(load_val);
        count_chg <= 1'b1;
      end else if (int_gate && (step_up ^ step_dn)) begin
        count     <= step_up ? count + 32'sh0000_0001
                             : count - 32'sh0000_0001;
        count_chg <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      latch_val <= 32'sh0000_0000;
    else if (latch_rise)
      latch_val <= count;
  end

  // Comparator with hysteresis band
  wire signed [33:0] c_ext = 34'(count);
  wire signed [33:0] v_ext = 34'(signed'(cmp_val));
  wire signed [33:0] h_ext = (hyst > 8'h01) ? 34'(hyst) : 34'sh0;
  assign hit = count_chg && (count == signed'(cmp_val)) && armed;

  always_comb begin
    next_cmp_out = 1'b0;
    case (out_mode)
      encoder_counter_pkg::OUT_GE:
        next_cmp_out = (c_ext >= v_ext) ? 1'b1 :
                       (c_ext < v_ext - h_ext) ? 1'b0 : cmp_out;
      encoder_counter_pkg::OUT_LE:
        next_cmp_out = (c_ext <= v_ext) ? 1'b1 :
                       (c_ext > v_ext + h_ext) ? 1'b0 : cmp_out;
      encoder_counter_pkg::OUT_PULSE:
        next_cmp_out = (pulse_dur == 9'h000) ? (c_ext == v_ext)
                                             : (pulse_left != 9'h000);
      default: next_cmp_out = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_out   <= 1'b0;
      cmp_out_q <= 1'b0;
      armed     <= 1'b1;
    end else begin
      cmp_out   <= next_cmp_out;
      cmp_out_q <= cmp_out;
      if (hit)
        armed <= 1'b0;
      else if (c_ext < v_ext - h_ext || c_ext > v_ext + h_ext)
        armed <= 1'b1;
    end
  end

  // Pulse length timer in 1.024 ms units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_left <= 9'h000;
      unit_div   <= 17'h0_0000;
    end else if (hit && out_mode == encoder_counter_pkg::OUT_PULSE) begin
      pulse_left <= pulse_dur;
      unit_div   <= 17'h0_0000;
    end else if (pulse_left != 9'h000) begin
      if (unit_div == 17'(pulse_unit_cyc - 1)) begin
        unit_div   <= 17'h0_0000;
        pulse_left <= pulse_left - 9'h001;
      end else begin
        unit_div <= unit_div + 17'h0_0001;
      end
    end
  end

  wire cmp_event = cmp_out & ~cmp_out_q & (out_mode != encoder_counter_pkg::OUT_NONE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      counter_do <= 1'b0;
    else if (out_mode == encoder_counter_pkg::OUT_NONE)
      counter_do <= ctrl[`EC_CTRL_SET_DO];
    else
      counter_do <= ctrl[`EC_CTRL_DO_EN] & cmp_out;
  end

  // Interrupt events
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pulse <= 1'b0;
      irq_cause <= 5'h00;
    end else begin
      irq_cause[`EC_IRQ_HW_OPEN]  <= int_en[`EC_IRQ_HW_OPEN] & hw_open
                                     & software_gate_bit;
      irq_cause[`EC_IRQ_HW_CLOSE] <= int_en[`EC_IRQ_HW_CLOSE] & hw_close
                                     & software_gate_bit;
      irq_cause[`EC_IRQ_CMP]  <= int_en[`EC_IRQ_CMP] & cmp_event;
      irq_cause[`EC_IRQ_OFLW] <= int_en[`EC_IRQ_OFLW] & ovf_evt;
      irq_cause[`EC_IRQ_UFLW] <= int_en[`EC_IRQ_UFLW] & ufl_evt;
      irq_pulse <= |(int_en[4:0] & {ufl_evt, ovf_evt, cmp_event,
                   hw_close & software_gate_bit, hw_open & software_gate_bit});
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  wire st_clr = wr_en && paddr[7:0] == `EC_ADDR_STATUS;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_reached_flag <= 1'b0;
      oflw_flag <= 1'b0;
      uflw_flag <= 1'b0;
    end else begin
      comparator_reached_flag <= cmp_event | (comparator_reached_flag &
                                 ~(st_clr & pwdata[`EC_ST_CMP]));
      oflw_flag <= ovf_evt | (oflw_flag & ~(st_clr & pwdata[`EC_ST_OFLW]));
      uflw_flag <= ufl_evt | (uflw_flag & ~(st_clr & pwdata[`EC_ST_UFLW]));
    end
  end

  // APB slave: one wait state, error on unmapped address
  wire mapped = (paddr[31:5] == 27'h000_0000) && (paddr[1:0] == 2'b00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite && mapped) begin
        case (paddr[7:0])
          `EC_ADDR_CTRL:   prdata <= ctrl;
          `EC_ADDR_INT_EN: prdata <= int_en;
          `EC_ADDR_CMP:    prdata <= cmp_val;
          `EC_ADDR_LOAD:   prdata <= load_val;
          `EC_ADDR_TIMING: prdata <= timing;
          `EC_ADDR_STATUS: prdata <= {25'h000_0000, uflw_flag, oflw_flag,
                                      comparator_reached_flag, counter_do,
                                      filt[3], filt[2], int_gate};
          `EC_ADDR_COUNT:  prdata <= count;
          default:         prdata <= latch_val;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `EC_CTRL_RESET;
      int_en   <= 32'h0000_0000;
      cmp_val  <= 32'h0000_0000;
      load_val <= 32'h0000_0000;
      timing   <= 32'h0000_0000;
    end else if (wr_en && mapped) begin
      case (paddr[7:0])
        `EC_ADDR_CTRL:   ctrl     <= {15'h0000, pwdata[16:0]};
        `EC_ADDR_INT_EN: int_en   <= {27'h000_0000, pwdata[4:0]};
        `EC_ADDR_CMP:    cmp_val  <= pwdata;
        `EC_ADDR_LOAD:   load_val <= pwdata;
        `EC_ADDR_TIMING: timing   <= {7'h00, pwdata[24:17], 1'b0, 8'h00,
                                      pwdata[7:0]};
        default: ;
      endcase
    end
  end

  a_gate_form: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 int_gate == ($past(software_gate_bit) & (~$past(hw_en) | $past(filt[2]))))
    else $error("internal gate does not follow software and hardware gate");
  a_latch_take: assert property (@(posedge pclk) disable iff (!presetn)
    latch_rise |=> latch_val == $past(count))
    else $error("latch did not capture the count");
  a_cancel_load: assert property (@(posedge pclk) disable iff (!presetn)
    gate_rise && !stop_mode |=> count == signed'($past(load_val)))
    else $error("cancel mode did not reload");
  a_closed_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !int_gate |=> count == $past(count))
    else $error("count moved while gate closed");
  a_ovf_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_evt |=> count == 32'sh8000_0000 ##1 oflw_flag)
    else $error("overflow did not wrap or flag");
  a_dir_up: assert property (@(posedge pclk) disable iff (!presetn)
    eval_mode == encoder_counter_pkg::EVAL_PULSE_DIR && int_gate && !gate_rise
    && a_rise && !(b_f ^ dir_inv) && !ovf_evt |=> count == $past(count) + 1)
    else $error("pulse did not count up");
  a_ge_level: assert property (@(posedge pclk) disable iff (!presetn)
    out_mode == encoder_counter_pkg::OUT_GE && c_ext >= v_ext |=> cmp_out)
    else $error("at-or-above output not set");
  a_none_out: assert property (@(posedge pclk) disable iff (!presetn)
    out_mode == encoder_counter_pkg::OUT_NONE |=> !cmp_out && !irq_cause[2])
    else $error("comparator active with no comparison");
  a_pulse_start: assert property (@(posedge pclk) disable iff (!presetn)
    hit && out_mode == encoder_counter_pkg::OUT_PULSE && pulse_dur != 9'h000
    |=> pulse_left == $past(pulse_dur) ##1 cmp_out)
    else $error("pulse did not start on reaching the value");

  c_latch:   cover property (@(posedge pclk) disable iff (!presetn) latch_rise);
  c_ovf:     cover property (@(posedge pclk) disable iff (!presetn) ovf_evt);
  c_cmp_irq: cover property (@(posedge pclk) disable iff (!presetn)
    irq_pulse && irq_cause[2]);
endmodule

// File: bench/encoder_model.sv
// Far-side model: encoder tracks, hardware gate and latch pins.
// Assumes the bench calls pins(); pins move right after a pclk edge.
`timescale 1ns/100ps
module encoder_model (
  input  wire logic pclk,    // System clock
  output logic      track_a, // Track A / pulse
  output logic      track_b, // Track B / direction
  output logic      gate,    // Hardware gate pin
  output logic      latch    // Latch pin
);
  initial {track_a, track_b, gate, latch} = 4'h0;
  // Holds the levels n cycles; a short n makes a glitch
  task automatic pins(input logic [3:0] v, input int n);
    @(posedge pclk);
    {track_a, track_b, gate, latch} <= v;
    repeat (n) @(posedge pclk);
  endtask
endmodule

// File: bench/encoder_counter_config_tb.sv
// Self-checking bench for the counter channel, APB master tasks.
// Assumes the reduced filter and pulse parameters set below.
`timescale 1ns/100ps
`include "encoder_counter_params.svh"
module encoder_counter_config_tb;
  localparam int          hold = 40;
  localparam logic [31:0] base = 32'h0000_4801;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [31:0] paddr, pwdata, prdata, rd, cnt;
  logic        track_a, track_b, gate, latch, counter_do, irq_pulse, g;
  logic [4:0]  irq_cause, irq_seen;
  logic [1:0]  q [4];
  int          mismatches, n_tests, cycles;

  encoder_counter_config #(
    .filt_cyc_10k(20), .filt_cyc_5k(30), .filt_cyc_2k(40),
    .filt_cyc_1k(50), .pulse_unit_cyc(16)
  ) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .track_a(track_a),
    .track_b(track_b), .hardware_gate_input(gate), .latch_in(latch),
    .counter_do(counter_do), .irq_pulse(irq_pulse), .irq_cause(irq_cause)
  );
  encoder_model model_u (
    .pclk(pclk), .track_a(track_a), .track_b(track_b), .gate(gate),
    .latch(latch)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (irq_pulse === 1'b1) irq_seen <= irq_seen | irq_cause;
    if (cycles == 30000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, {24'h0, a}, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, {24'h0, a}, 32'h0);
    chk(rd, exp);
  endtask

  task automatic irq_chk(input logic [4:0] exp);
    chk({27'h0, irq_seen}, {27'h0, exp});
    irq_seen = 5'h0;
  endtask

  task automatic pulse(input logic b);
    model_u.pins({1'b1, b, g, 1'b0}, hold);
    model_u.pins({1'b0, b, g, 1'b0}, hold);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, g, se} = 6'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    irq_seen = 5'h0;
    q = '{2'b10, 2'b11, 2'b01, 2'b00};
    {mismatches, n_tests, cycles} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`EC_ADDR_CTRL, 32'h0000_4400);
    rd_chk(`EC_ADDR_INT_EN, 32'h0000_0000);
    rd_chk(`EC_ADDR_TIMING, 32'h0000_0000);
    rd_chk(`EC_ADDR_COUNT, 32'h0000_0000);
    apb(1'b0, 32'h0000_0020, 32'h0);
    chk({31'h0, se}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    // Pulse and direction counting, inversion, glitch, latch
    wr(`EC_ADDR_CTRL, base);
    repeat (3) pulse(1'b0);
    rd_chk(`EC_ADDR_COUNT, 32'h0000_0003);
    pulse(1'b1);
    rd_chk(`EC_ADDR_COUNT, 32'h0000_0002);
    wr(`EC_ADDR_CTRL, base | 32'h0000_0010);
    pulse(1'b1);
    rd_chk(`EC_ADDR_COUNT, 32'h0000_0003);
    model_u.pins(4'h8, 5);
    model_u.pins(4'h0, hold);
    rd_chk(`EC_ADDR_COUNT, 32'h0000_0003);
    model_u.pins(4'h1, hold);
    model_u.pins(4'h0, hold);
    rd_chk(`EC_ADDR_LATCH, 32'h0000_0003);
    wr(`EC_ADDR_CTRL, 32'h0000_4800);
    pulse(1'b0);
    rd_chk(`EC_ADDR_COUNT, 32'h0000_0003);
    wr(`EC_ADDR_CTRL, base);
    rd_chk(`EC_ADDR_COUNT, 32'h0000_0000);
    // One forward quadrature cycle in each quadrature mode: x1, x2, x4
    cnt = 32'h0;
    for (int m = 1; m < 4; m++) begin
      wr(`EC_ADDR_CTRL, base | 32'(m << 5));
      foreach (q[i]) model_u.pins({q[i], g, 1'b0}, hold);
      cnt = cnt + 32'(1 << (m - 1));
      rd_chk(`EC_ADDR_COUNT, cnt);
    end
    // Comparator at or above, then software output
    wr(`EC_ADDR_CMP, cnt + 32'h1);
    wr(`EC_ADDR_INT_EN, 32'h0000_0004);
    wr(`EC_ADDR_CTRL, base | 32'h0000_0102);
    repeat (4) @(posedge pclk);
    chk({31'h0, counter_do}, 32'h0);
    pulse(1'b0);
    chk({31'h0, counter_do}, 32'h1);
    irq_chk(5'h04);
    rd_chk(`EC_ADDR_STATUS, 32'h0000_0019);
    pulse(1'b1);
    chk({31'h0, counter_do}, 32'h0);
    wr(`EC_ADDR_CTRL, base | 32'h0000_0004);
    pulse(1'b0);
    chk({31'h0, counter_do}, 32'h1);
    irq_chk(5'h00);
    // Wrap at the count limits, then stop mode
    wr(`EC_ADDR_LOAD, 32'h7FFF_FFFF);
    wr(`EC_ADDR_INT_EN, 32'h0000_0018);
    wr(`EC_ADDR_CTRL, 32'h0000_4800);
    wr(`EC_ADDR_CTRL, base);
    rd_chk(`EC_ADDR_COUNT, 32'h7FFF_FFFF);
    pulse(1'b0);
    rd_chk(`EC_ADDR_COUNT, 32'h8000_0000);
    irq_chk(5'h08);
    pulse(1'b1);
    irq_chk(5'h10);
    wr(`EC_ADDR_CTRL, 32'h0001_4800);
    pulse(1'b0);
    wr(`EC_ADDR_LOAD, 32'h0000_0000);
    wr(`EC_ADDR_CTRL, 32'h0001_4801);
    rd_chk(`EC_ADDR_COUNT, 32'h7FFF_FFFF);
    // Hardware gate with its interrupts, cancel mode
    wr(`EC_ADDR_INT_EN, 32'h0000_0003);
    wr(`EC_ADDR_CTRL, base | 32'h0000_0008);
    pulse(1'b0);
    rd_chk(`EC_ADDR_COUNT, 32'h7FFF_FFFF);
    g = 1'b1;
    model_u.pins(4'h2, hold);
    irq_chk(5'h01);
    pulse(1'b1);
    rd_chk(`EC_ADDR_COUNT, 32'hFFFF_FFFF);
    g = 1'b0;
    model_u.pins(4'h0, hold);
    irq_chk(5'h02);
    pulse(1'b1);
    rd_chk(`EC_ADDR_COUNT, 32'hFFFF_FFFF);
    // Hysteresis at or below, timed pulse, slower latch filter
    wr(`EC_ADDR_CTRL, base);
    wr(`EC_ADDR_CMP, 32'h0000_0002);
    wr(`EC_ADDR_TIMING, 32'h0000_0003);
    wr(`EC_ADDR_CTRL, base | 32'h0000_0202);
    repeat (4) @(posedge pclk);
    chk({31'h0, counter_do}, 32'h1);
    repeat (3) pulse(1'b0);
    chk({31'h0, counter_do}, 32'h1);
    repeat (3) pulse(1'b0);
    chk({31'h0, counter_do}, 32'h0);
    wr(`EC_ADDR_CMP, 32'h0000_0008);
    wr(`EC_ADDR_TIMING, 32'h0008_0000);
    wr(`EC_ADDR_INT_EN, 32'h0000_0004);
    wr(`EC_ADDR_CTRL, base | 32'h0000_0302);
    repeat (2) pulse(1'b0);
    chk({31'h0, counter_do}, 32'h1);
    irq_chk(5'h04);
    repeat (100) @(posedge pclk);
    chk({31'h0, counter_do}, 32'h0);
    wr(`EC_ADDR_CTRL, 32'h0000_A801);
    model_u.pins(4'h1, hold);
    model_u.pins(4'h0, hold);
    rd_chk(`EC_ADDR_LATCH, 32'h0000_0003);
    complete_run();
  end
endmodule
